// file: hdl/battery_charge_state_params.svh
// Register offsets, field positions, reset values and timing constants
`ifndef BATTERY_CHARGE_STATE_PARAMS_SVH
`define BATTERY_CHARGE_STATE_PARAMS_SVH

`define OFS_CTRL        8'h00
`define OFS_DESIGN      8'h04
`define OFS_RESERVE     8'h08
`define OFS_LOW_THR     8'h0c
`define OFS_FINAL_THR   8'h10
`define OFS_USER_RATE   8'h14
`define OFS_CHG_EFF     8'h18
`define OFS_INT_EN      8'h1c
`define OFS_INT_CLR     8'h20
`define OFS_INT_STATUS  8'h24
`define OFS_STATUS      8'h28
`define OFS_CAPACITY    8'h2c
`define OFS_SOC         8'h30
`define OFS_RATE        8'h34
`define OFS_CHARGE      8'h38

`define NUM_RW_REGS     8
`define RST_CTRL        32'h0000_0110
`define RST_DESIGN      32'h0e10_03e8
`define RST_RESERVE     32'h0000_0000
`define RST_LOW_THR     32'h00af_0096
`define RST_FINAL_THR   32'h0064_004b
`define RST_USER_RATE   32'h0000_0000
`define RST_CHG_EFF     32'hffff_ffff
`define RST_INT_EN      32'h0000_0000

`define FINAL_DISABLED  16'hffff
`define ACC_FRAC        12
`define DSG_THRESH      17'sh00010
`define PRES_SHIFT      4
`define AVG_SHIFT       2
`define FILT_SHIFT      6
`define LOSS_SHIFT      4
`define RESP_OKAY       2'b00
`define RESP_SLVERR     2'b10

`endif

// file: hdl/battery_charge_state_pkg.sv
// Types shared by the charge-state logic
package battery_charge_state_pkg;

    typedef enum logic [2:0] {
        RATE_PREV    = 3'h0,
        RATE_PRESENT = 3'h1,
        RATE_AVERAGE = 3'h2,
        RATE_FILTER  = 3'h3,
        RATE_DESIGN  = 3'h4,
        RATE_RSVD5   = 3'h5,
        RATE_USER    = 3'h6,
        RATE_RSVD7   = 3'h7
    } rate_sel_t;

    typedef struct packed {
        logic [3:0] energyScale;
        logic [0:0] pad0;
        rate_sel_t  rateSel;
        logic       pad1;
        logic       reserveCompSelect;
        logic       loadModel;
        logic       socRiseHold;
    } cfg_t;

    typedef struct packed {
        logic discharging;
        logic holdActive;
        logic loadModelStatus;
        logic finalChargeWarning;
        logic lowChargeWarning;
    } status_t;

endpackage

// file: hdl/battery_charge_state_logic.sv
// Charge integration, capacity reporting, warnings and AXI4-Lite registers
// Notes on behaviour
// - Integrate sensed charge from sense_pos minus sense_neg in both directions.
// - Full capacity is deliverable capacity under present load to termination.
// - With hold enabled, reported charge state never rises during discharge.
// - Low warning sets below its set level, clears above its clear level.
// - Final warning sets when remaining capacity drops below its set level.
// - Final set level of minus one disables setting the final warning.
// - Final warning clears only if set and capacity exceeds clear level.
// - Load model zero is constant current (default), one is constant power.
// - Control status word mirrors the load model setting.
// - In current mode the rate selector picks the current rate source.
// - In power mode the rate selector picks the power rate source.
// - Reserve capacity and reserve energy are withheld, reporting zero early.
// - Reserve compensation uses loaded or no-load rate per its select bit.
// - Energy parameters are in units multiplied by the energy scale.
// - Charge gained is corrected by four charge efficiency factors.
//
// Implementation choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`include "battery_charge_state_params.svh"

module battery_charge_state_logic (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        arst_n,
    // Measurement samples
    input  wire logic        sampleValid,
    input  wire logic [15:0] sensePos,
    input  wire logic [15:0] senseNeg,
    input  wire logic [15:0] cellVoltage,
    // AXI4-Lite write address
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [7:0]  awaddr,
    input  wire logic [2:0]  awprot,
    // AXI4-Lite write data
    input  wire logic        wvalid,
    output logic             wready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    // AXI4-Lite write response
    output logic             bvalid,
    input  wire logic        bready,
    output logic [1:0]       bresp,
    // AXI4-Lite read address
    input  wire logic        arvalid,
    output logic             arready,
    input  wire logic [7:0]  araddr,
    input  wire logic [2:0]  arprot,
    // AXI4-Lite read data
    output logic             rvalid,
    input  wire logic        rready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    // Warnings and interrupt
    output logic             lowChargeWarning,
    output logic             finalChargeWarning,
    output logic             irq
);

    logic        rstMeta;
    logic        rstSync;
    logic [31:0] rwReg [`NUM_RW_REGS];
    localparam logic [31:0] RW_RESET [`NUM_RW_REGS] = '{`RST_CTRL, `RST_DESIGN, `RST_RESERVE,
        `RST_LOW_THR, `RST_FINAL_THR, `RST_USER_RATE, `RST_CHG_EFF, `RST_INT_EN};
    logic        awHeld;
    logic        wHeld;
    logic [7:0]  wrAddr;
    logic [31:0] wrData;
    logic [3:0]  wrStrb;
    logic        doWrite;
    logic        wrMapped;
    logic [31:0] rdWord;
    logic        rdMapped;
    logic [31:0] byteMask;
    logic [3:0]  intStatus;
    logic [3:0]  intEvent;
    logic [3:0]  intClear;

    battery_charge_state_pkg::cfg_t    cfg;
    battery_charge_state_pkg::status_t status;

    logic signed [16:0] diff;
    logic [15:0]        mag;
    logic               charging;
    logic               dsgNow;
    logic [7:0]         eff;
    logic signed [25:0] effProd;
    logic signed [29:0] delta;
    logic signed [29:0] accSum;
    logic [27:0]        accMax;
    logic [27:0]        acc;
    logic [31:0]        instPowFull;
    logic [15:0]        instPow;
    logic [15:0]        presAvg;
    logic [15:0]        prevAvg;
    logic [15:0]        presPow;
    logic [15:0]        prevPow;
    logic [15:0]        avgCur;
    logic [15:0]        filtCur;
    logic               firstCycle;
    logic               updTick;
    logic               dsgEnd;
    logic               discharging;

    logic [15:0] designCap;
    logic [19:0] designEnergy;
    logic [15:0] reserveCap;
    logic [19:0] reserveEnergy;
    logic [19:0] userPower;
    logic [31:0] avgCurPowFull;
    logic [31:0] filtPowFull;
    logic [19:0] next_rate;
    logic [15:0] loss;
    logic [15:0] nomRc;
    logic [15:0] next_fcc;
    logic [15:0] trueRc;
    logic [16:0] reserveUsed;
    logic [15:0] next_rc;
    logic [23:0] socNum;
    logic [23:0] socQuot;
    logic [7:0]  next_soc;
    logic [31:0] energyFull;
    logic [20:0] energyReserve;
    logic [15:0] next_energy;
    logic [19:0] rate;
    logic [15:0] rc;
    logic [15:0] fcc;
    logic [7:0]  soc;
    logic [15:0] energy;
    logic        holdActive;
    logic        next_low;
    logic        next_final;

    // Reset release through two flip-flops
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rstMeta <= 1'b0;
            rstSync <= 1'b0;
        end
        else
        begin
            rstMeta <= 1'b1;
            rstSync <= rstMeta;
        end
    end

    // AXI4-Lite write path: address and data accepted in either order
    assign doWrite  = awHeld && wHeld && !bvalid;
    assign byteMask = {{8{wrStrb[3]}}, {8{wrStrb[2]}}, {8{wrStrb[1]}}, {8{wrStrb[0]}}};
    assign wrMapped = (wrAddr[1:0] == 2'b00) && (wrAddr <= `OFS_INT_CLR);

    always_ff @(posedge sys_clk or negedge rstSync)
    begin
        if (!rstSync)
        begin
            awHeld  <= 1'b0;
            wHeld   <= 1'b0;
            awready <= 1'b1;
            wready  <= 1'b1;
            bvalid  <= 1'b0;
            bresp   <= `RESP_OKAY;
            wrAddr  <= 8'h00;
            wrData  <= 32'h0000_0000;
            wrStrb  <= 4'h0;
        end
        else
        begin
            if (awvalid && awready)
            begin
                awHeld  <= 1'b1;
                awready <= 1'b0;
                wrAddr  <= awaddr;
            end
            if (wvalid && wready)
            begin
                wHeld  <= 1'b1;
                wready <= 1'b0;
                wrData <= wdata;
                wrStrb <= wstrb;
            end
            if (doWrite)
            begin
                bvalid <= 1'b1;
                bresp  <= wrMapped ? `RESP_OKAY : `RESP_SLVERR;
            end
            if (bvalid && bready)
            begin
                bvalid  <= 1'b0;
                awHeld  <= 1'b0;
                wHeld   <= 1'b0;
                awready <= 1'b1;
                wready  <= 1'b1;
            end
        end
    end

    // Writable words honour byte strobes
    generate
        for (genvar i = 0; i < `NUM_RW_REGS; i++)
        begin : gen_rw
            always_ff @(posedge sys_clk or negedge rstSync)
            begin
                if (!rstSync)
                    rwReg[i] <= RW_RESET[i];
                else if (doWrite && wrMapped && wrAddr[7:2] == 6'(i))
                    rwReg[i] <= (rwReg[i] & ~byteMask) | (wrData & byteMask);
            end
        end
    endgenerate

    assign cfg           = battery_charge_state_pkg::cfg_t'(rwReg[0][11:0]);
    assign designCap     = rwReg[1][15:0];
    // energy-valued settings carry the scale factor before use
    assign designEnergy  = rwReg[1][31:16] * cfg.energyScale;
    assign reserveCap    = rwReg[2][15:0];
    assign reserveEnergy = rwReg[2][31:16] * cfg.energyScale;
    assign userPower     = rwReg[5][31:16] * cfg.energyScale;

    // Clear register is write-only; a pulse per written one bit
    assign intClear = (doWrite && wrAddr == `OFS_INT_CLR && wrStrb[0]) ? wrData[3:0] : 4'h0;

    // AXI4-Lite read path
    always_comb
    begin
        rdWord   = 32'h0000_0000;
        rdMapped = (araddr[1:0] == 2'b00);
        unique case (araddr)
            `OFS_CTRL, `OFS_DESIGN, `OFS_RESERVE, `OFS_LOW_THR,
            `OFS_FINAL_THR, `OFS_USER_RATE, `OFS_CHG_EFF, `OFS_INT_EN:
                rdWord = rwReg[araddr[4:2]];
            `OFS_INT_CLR:    rdWord = 32'h0000_0000;
            `OFS_INT_STATUS: rdWord = {28'h000_0000, intStatus};
            `OFS_STATUS:     rdWord = {27'h000_0000, status};
            `OFS_CAPACITY:   rdWord = {fcc, rc};
            `OFS_SOC:        rdWord = {energy, 8'h00, soc};
            `OFS_RATE:       rdWord = {12'h000, rate};
            `OFS_CHARGE:     rdWord = {16'h0000, nomRc};
            default:         rdMapped = 1'b0;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rstSync)
    begin
        if (!rstSync)
        begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
            rdata   <= 32'h0000_0000;
            rresp   <= `RESP_OKAY;
        end
        else if (arvalid && arready)
        begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rdata   <= rdMapped ? rdWord : 32'h0000_0000;
            rresp   <= rdMapped ? `RESP_OKAY : `RESP_SLVERR;
        end
        else if (rvalid && rready)
        begin
            rvalid  <= 1'b0;
            arready <= 1'b1;
        end
    end

    // Sense difference; positive means charge flowing into the cell
    assign diff     = {sensePos[15], sensePos} - {senseNeg[15], senseNeg};
    assign mag      = diff[16] ? 16'(-diff) : diff[15:0];
    assign charging = !diff[16] && diff != 17'sh00000;
    assign dsgNow   = diff < -`DSG_THRESH;

    // Efficiency factor chosen by charge-state quarter, so the correction can bend
    always_comb
    begin
        if (soc >= 8'd75)
            eff = rwReg[6][31:24];
        else if (soc >= 8'd50)
            eff = rwReg[6][23:16];
        else if (soc >= 8'd25)
            eff = rwReg[6][15:8];
        else
            eff = rwReg[6][7:0];
    end

    assign effProd = diff * $signed({1'b0, eff});
    assign delta   = charging ? 30'(effProd >>> 8) : 30'(diff);
    assign accSum  = $signed({2'b00, acc}) + delta;
    assign accMax  = {designCap, 12'h000};

    // Charge integrator clamped between empty and design capacity
    always_ff @(posedge sys_clk or negedge rstSync)
    begin
        if (!rstSync)
            acc <= 28'h000_0000;
        else if (sampleValid)
        begin
            if (accSum < 0)
                acc <= 28'h000_0000;
            else if (accSum > $signed({2'b00, accMax}))
                acc <= accMax;
            else
                acc <= accSum[27:0];
        end
    end

    assign nomRc       = acc[27:`ACC_FRAC];
    assign instPowFull = mag * cellVoltage;
    assign instPow     = instPowFull[25:10];

    function automatic logic [15:0] ema(input logic [15:0] a, input logic [15:0] x,
                                         input int sh);
        ema = a - (a >> sh) + (x >> sh);
    endfunction

    // Discharge-cycle averages; previous-cycle values latch at discharge end
    always_ff @(posedge sys_clk or negedge rstSync)
    begin
        if (!rstSync)
        begin
            discharging <= 1'b0;
            presAvg    <= 16'h0000;
            prevAvg    <= 16'h0000;
            presPow    <= 16'h0000;
            prevPow    <= 16'h0000;
            avgCur     <= 16'h0000;
            filtCur    <= 16'h0000;
            firstCycle <= 1'b1;
            dsgEnd     <= 1'b0;
            updTick    <= 1'b0;
        end
        else
        begin
            updTick <= sampleValid;
            dsgEnd  <= sampleValid && discharging && !dsgNow;
            if (sampleValid)
            begin
                discharging <= dsgNow;
                avgCur  <= ema(avgCur, dsgNow ? mag : 16'h0000, `AVG_SHIFT);
                filtCur <= ema(filtCur, dsgNow ? mag : 16'h0000, `FILT_SHIFT);
                if (dsgNow && !discharging)
                begin
                    presAvg <= mag;
                    presPow <= instPow;
                end
                else if (dsgNow)
                begin
                    presAvg <= ema(presAvg, mag, `PRES_SHIFT);
                    presPow <= ema(presPow, instPow, `PRES_SHIFT);
                end
                else if (discharging)
                begin
                    prevAvg    <= presAvg;
                    prevPow    <= presPow;
                    firstCycle <= 1'b0;
                end
            end
        end
    end

    assign avgCurPowFull = avgCur * cellVoltage;
    assign filtPowFull   = filtCur * cellVoltage;

    // Rate source selection for the load model
    always_comb
    begin
        next_rate = 20'h0_0000;
        if (!cfg.loadModel)
        begin
            unique case (cfg.rateSel)
                battery_charge_state_pkg::RATE_PREV:
                    next_rate = {4'h0, firstCycle ? presAvg : prevAvg};
                battery_charge_state_pkg::RATE_AVERAGE: next_rate = {4'h0, avgCur};
                battery_charge_state_pkg::RATE_FILTER:  next_rate = {4'h0, filtCur};
                battery_charge_state_pkg::RATE_DESIGN:  next_rate = {4'h0, designCap / 16'd5};
                battery_charge_state_pkg::RATE_USER:    next_rate = {4'h0, rwReg[5][15:0]};
                default:                                next_rate = {4'h0, presAvg};
            endcase
        end
        else
        begin
            unique case (cfg.rateSel)
                battery_charge_state_pkg::RATE_PRESENT: next_rate = {4'h0, presPow};
                battery_charge_state_pkg::RATE_AVERAGE: next_rate = {4'h0, avgCurPowFull[25:10]};
                battery_charge_state_pkg::RATE_FILTER:  next_rate = {4'h0, filtPowFull[25:10]};
                battery_charge_state_pkg::RATE_DESIGN:  next_rate = designEnergy / 20'd5;
                battery_charge_state_pkg::RATE_USER:    next_rate = userPower;
                default:
                    next_rate = {4'h0, firstCycle ? presPow : prevPow};
            endcase
        end
    end

    // Load-dependent loss lowers both full and remaining capacity
    assign loss     = next_rate[19:`LOSS_SHIFT];
    assign next_fcc = (designCap > loss) ? designCap - loss : 16'h0000;
    assign trueRc   = (nomRc > loss) ? nomRc - loss : 16'h0000;

    // Set select bit means no-load compensation of the reserve
    assign reserveUsed = cfg.reserveCompSelect ? {1'b0, reserveCap}
                         : {1'b0, reserveCap} + {3'b000, loss[15:2]};
    assign next_rc     = ({1'b0, trueRc} > reserveUsed) ? 16'(trueRc - reserveUsed[15:0])
                         : 16'h0000;

    assign socNum  = next_rc * 24'd100;
    assign socQuot = (next_fcc == 16'h0000) ? 24'h00_0000 : socNum / {8'h00, next_fcc};
    assign next_soc = socQuot[7:0];

    assign energyFull    = next_rc * cellVoltage;
    assign energyReserve = cfg.reserveCompSelect ? {1'b0, reserveEnergy}
                           : {1'b0, reserveEnergy} + {7'h00, loss[15:2]};
    assign next_energy   = ({5'h00, energyFull[25:10]} > energyReserve)
                           ? 16'(energyFull[25:10] - energyReserve[15:0]) : 16'h0000;

    // Signed threshold comparisons; hysteresis keeps the old flag between levels
    always_comb
    begin
        next_low   = lowChargeWarning;
        next_final = finalChargeWarning;
        if ($signed({1'b0, next_rc}) < $signed({rwReg[3][15], rwReg[3][15:0]}))
            next_low = 1'b1;
        else if ($signed({1'b0, next_rc}) > $signed({rwReg[3][31], rwReg[3][31:16]}))
            next_low = 1'b0;
        if (rwReg[4][15:0] != `FINAL_DISABLED &&
            $signed({1'b0, next_rc}) < $signed({rwReg[4][15], rwReg[4][15:0]}))
            next_final = 1'b1;
        else if (finalChargeWarning &&
                 $signed({1'b0, next_rc}) > $signed({rwReg[4][31], rwReg[4][31:16]}))
            next_final = 1'b0;
    end

    // Reported results refresh one cycle after each sample
    always_ff @(posedge sys_clk or negedge rstSync)
    begin
        if (!rstSync)
        begin
            rate       <= 20'h0_0000;
            rc         <= 16'h0000;
            fcc        <= 16'h0000;
            soc        <= 8'h00;
            energy     <= 16'h0000;
            holdActive <= 1'b0;
            lowChargeWarning   <= 1'b0;
            finalChargeWarning <= 1'b0;
        end
        else if (updTick)
        begin
            rate   <= next_rate;
            rc     <= next_rc;
            fcc    <= next_fcc;
            energy <= next_energy;
            holdActive <= cfg.socRiseHold && discharging && next_soc > soc;
            if (cfg.socRiseHold && discharging && next_soc > soc)
                soc <= soc;
            else
                soc <= next_soc;
            lowChargeWarning   <= next_low;
            finalChargeWarning <= next_final;
        end
    end

    assign status = {discharging, holdActive, cfg.loadModel, finalChargeWarning,
                     lowChargeWarning};

    // Sticky events: low set, final set, update, discharge end; set beats clear
    assign intEvent = {dsgEnd, updTick,
                       updTick && next_final && !finalChargeWarning,
                       updTick && next_low && !lowChargeWarning};

    always_ff @(posedge sys_clk or negedge rstSync)
    begin
        if (!rstSync)
        begin
            intStatus <= 4'h0;
            irq       <= 1'b0;
        end
        else
        begin
            intStatus <= (intStatus & ~intClear) | intEvent;
            irq       <= |(intStatus & rwReg[7][3:0]);
        end
    end

endmodule

// file: tb/battery_charge_state_assertions.sv
// Port-level assertions for the charge-state block
`timescale 1ns/1ps
`include "battery_charge_state_params.svh"
module battery_charge_state_checker (
    // Clock, reset and watched signals
    input wire logic        sys_clk, arst_n, sampleValid, awvalid, awready, wvalid, wready,
    input wire logic        bvalid, bready, arvalid, arready, rvalid, rready, irq,
    input wire logic        lowChargeWarning, finalChargeWarning,
    input wire logic [1:0]  bresp,
    input wire logic [31:0] rdata
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!arst_n);
    a_aw_refuse: assert property (awvalid && awready |=> !awready)
        else $error("write address taken twice");
    a_write_answer: assert property (awvalid && awready && wvalid && wready
        |=> !bvalid ##[1:2] bvalid) else $error("write response missing");
    a_resp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped");
    a_resp_code: assert property (bvalid |-> bresp == `RESP_OKAY || bresp == `RESP_SLVERR)
        else $error("bad response code");
    a_read_answer: assert property (arvalid && arready |=> rvalid && !arready)
        else $error("read data missing");
    a_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data dropped");
    // Flags may only move as the result of a capacity update
    a_low_timing: assert property ($changed(lowChargeWarning) |-> $past(sampleValid, 2))
        else $error("low warning moved off update");
    a_final_timing: assert property ($changed(finalChargeWarning) |-> $past(sampleValid, 2))
        else $error("final warning moved off update");
    c_slverr: cover property (bvalid && bready && bresp == `RESP_SLVERR);
    c_low_set: cover property ($rose(lowChargeWarning));
    c_irq: cover property ($rose(irq));
endmodule
bind battery_charge_state_logic battery_charge_state_checker chk_u (
    .sys_clk(sys_clk), .arst_n(arst_n), .sampleValid(sampleValid), .awvalid(awvalid),
    .awready(awready), .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready),
    .arvalid(arvalid), .arready(arready), .rvalid(rvalid), .rready(rready), .irq(irq),
    .lowChargeWarning(lowChargeWarning), .finalChargeWarning(finalChargeWarning),
    .bresp(bresp), .rdata(rdata));

// file: tb/battery_charge_state_logic_tb.sv
// Self-checking bench for the charge-state block
`timescale 1ns/1ps
`include "battery_charge_state_params.svh"
module battery_charge_state_logic_tb;
    logic        sys_clk, arst_n, sampleValid, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid, irq;
    logic        lowChargeWarning, finalChargeWarning;
    logic [15:0] sensePos, senseNeg, cellVoltage;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, rd, prev;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, resp;
    int          fails, checks_done, rc, fSet, low, fin, n;
    logic [31:0] rstVal [8] = '{`RST_CTRL, `RST_DESIGN, `RST_RESERVE, `RST_LOW_THR,
                                `RST_FINAL_THR, `RST_USER_RATE, `RST_CHG_EFF, `RST_INT_EN};
    int          tCfg [6] = '{'h140, 'h160, 'h142, 'h162, 'h242, 'h262};
    int          tExp [6] = '{200, 300, 720, 40, 1440, 80};

    battery_charge_state_logic dut_u (
        .sys_clk(sys_clk), .arst_n(arst_n), .sampleValid(sampleValid), .sensePos(sensePos),
        .senseNeg(senseNeg), .cellVoltage(cellVoltage), .awvalid(awvalid), .awready(awready),
        .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata),
        .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
        .arready(arready), .araddr(araddr), .arprot(3'h0), .rvalid(rvalid), .rready(rready),
        .rdata(rdata), .rresp(rresp), .lowChargeWarning(lowChargeWarning),
        .finalChargeWarning(finalChargeWarning), .irq(irq));

    initial
    begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("checks_done=%0d fails=%0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // One bus cycle; the response code lands in resp, read data in rd
    task automatic xfer(input bit w, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        {awvalid, wvalid, bready, arvalid, rready} <= {w, w, w, !w, !w};
        {awaddr, araddr, wdata} <= {a, a, d};
        n = 0;
        do
        begin
            @(posedge sys_clk);
            n++;
            awvalid <= awvalid & !awready;
            wvalid  <= wvalid & !wready;
            arvalid <= arvalid & !arready;
        end while ((w ? bvalid : rvalid) !== 1'b1 && n < 60);
        {bready, rready} <= 2'b00;
        {resp, rd} = w ? {bresp, 32'h0} : {rresp, rdata};
        if ((w ? bvalid : rvalid) !== 1'b1)
        begin
            chk(32'h0, 32'h1);
            report_and_stop();
        end
    endtask

    // Results settle two edges after the sample; one more for the interrupt
    task automatic samp(input int c);
        int s;
        s = $urandom_range(500, 0);
        @(posedge sys_clk);
        sampleValid <= 1'b1;
        sensePos    <= 16'(c + s);
        senseNeg    <= 16'(s);
        cellVoltage <= 16'($urandom_range(4200, 3000));
        @(posedge sys_clk);
        sampleValid <= 1'b0;
        repeat (3) @(posedge sys_clk);
    endtask

    initial
    begin
        {arst_n, sampleValid, awvalid, wvalid, bready, arvalid, rready} = '0;
        {sensePos, senseNeg, cellVoltage, awaddr, araddr, wdata} = '0;
        wstrb = 4'hf;
        {fails, checks_done, low, fin, fSet} = {32'd0, 32'd0, 32'd0, 32'd0, 32'd75};
        void'($urandom(32'hb7ba));
        repeat (5) @(posedge sys_clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        for (int k = 0; k < 8; k++)
        begin
            xfer(0, 8'(k * 4), 0);
            chk(rd, rstVal[k]);
        end
        xfer(0, 8'h3c, 0);
        chk(rd, 0);
        chk(32'(resp), 32'(`RESP_SLVERR));
        xfer(1, 8'h01, 32'h3);
        chk(32'(resp), 32'(`RESP_SLVERR));
        xfer(0, `OFS_CTRL, 0);
        chk(rd, `RST_CTRL);
        xfer(0, `OFS_CHARGE, 0);
        prev = rd;
        // Charge up through both clear levels, then drain with the final set disabled
        for (int i = 0; i < 70; i++)
        begin
            if (i == 30)
            begin
                xfer(1, `OFS_FINAL_THR, 32'h0064_ffff);
                fSet = -1;
            end
            samp(i < 30 ? int'($urandom_range(31000, 28000)) : -int'($urandom_range(31000, 28000)));
            xfer(0, `OFS_CHARGE, 0);
            chk(32'(i < 30 ? rd > prev || rd == 1000 : rd < prev || rd == 0), 1);
            prev = rd;
            xfer(0, `OFS_CAPACITY, 0);
            rc = int'(signed'(rd[15:0]));
            low = rc < 150 ? 1 : (rc > 175 ? 0 : low);
            fin = (fSet != -1 && rc < fSet) ? 1 : ((fin == 1 && rc > 100) ? 0 : fin);
            chk(32'(lowChargeWarning), 32'(low));
            chk(32'(finalChargeWarning), 32'(fin));
            xfer(0, `OFS_STATUS, 0);
            chk(32'(rd[1:0]), 32'({fin[0], low[0]}));
        end
        xfer(1, `OFS_INT_CLR, 32'hf);
        xfer(0, `OFS_INT_STATUS, 0);
        chk(rd, 0);
        samp(0);
        xfer(0, `OFS_INT_STATUS, 0);
        chk(32'(rd[2]), 1);
        chk(32'(irq), 0);
        xfer(1, `OFS_INT_EN, 32'h4);
        repeat (2) @(posedge sys_clk);
        chk(32'(irq), 1);
        xfer(1, `OFS_INT_CLR, 32'h4);
        repeat (2) @(posedge sys_clk);
        chk(32'(irq), 0);
        xfer(1, `OFS_USER_RATE, 32'h0028_012c);
        for (int k = 0; k < 6; k++)
        begin
            xfer(1, `OFS_CTRL, 32'(tCfg[k]));
            samp(0);
            xfer(0, `OFS_RATE, 0);
            chk(32'(rd[19:0]), 32'(tExp[k]));
            xfer(0, `OFS_STATUS, 0);
            chk(32'(rd[2]), 32'(tCfg[k][1]));
        end
        report_and_stop();
    end
endmodule
